// *** rtl/pcab_bridge.sv ***
`timescale 1ns/100ps
module pcab_bridge (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic host_req,
	input wire logic [1:0] host_kind,
	input wire logic host_wr,
	input wire logic [31:0] host_addr,
	input wire logic [1:0] host_size,
	input wire logic [7:0] host_len,
	input wire logic [31:0] host_wdata,
	output logic host_ack,
	output logic host_beat,
	output logic host_busy,
	output logic host_abort,
	output logic [31:0] host_rdata,
	output logic bus_clk,
	input wire logic [31:0] ad_in,
	output logic [31:0] ad_out,
	output logic ad_oe,
	output logic [3:0] cbe_out,
	output logic cbe_oe,
	output logic frame_n_out,
	output logic frame_oe,
	output logic irdy_n_out,
	output logic irdy_oe,
	input wire logic trdy_n_in,
	input wire logic devsel_n_in
);

	typedef struct packed {
		pcab_pkg::pcab_state_t st;
		logic [5:0] acc;
		logic bus_clk;
		logic [31:0] tsel;
		logic [31:0] addr;
		logic [3:0] cmd;
		logic [3:0] be;
		logic wr;
		logic [7:0] left;
		logic [3:0] wait_cnt;
		logic [2:0] lat;
		logic [31:0] ad_o;
		logic ad_oe;
		logic [3:0] cbe_o;
		logic cbe_oe;
		logic frame_n;
		logic frame_oe;
		logic irdy_n;
		logic irdy_oe;
		logic ack;
		logic beat;
		logic busy;
		logic abort;
		logic [31:0] rdata;
	} pcab_reg_t;

	pcab_reg_t r;
	pcab_reg_t n;
	pcab_pin_if #(.W(34)) pins ();
	logic [6:0] acc_sum;
	logic tick;
	logic [31:0] cfg_addr;
	logic [20:0] idsel;
	logic [3:0] io_be;
	logic trdy_ok;
	logic devsel_ok;
	logic [31:0] ad_seen;

	// Bus inputs enter through the three-stage synchroniser
	assign pins.raw = {ad_in, trdy_n_in, devsel_n_in};
	assign ad_seen = pins.clean[33:2];
	assign trdy_ok = ~pins.clean[1];
	assign devsel_ok = ~pins.clean[0];

	pcab_pin_sync #(.W(34), .INIT(pcab_pkg::PIN_RESET)) u_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.pins(pins)
	);

	// Configuration address built from the target-select register
	always_comb begin
		idsel = 21'h000000;
		if (r.tsel[15:11] <= pcab_pkg::IDSEL_MAX_DEV) begin
			idsel = 21'(21'h000001 << r.tsel[15:11]);
		end
		if (r.tsel[1:0] == pcab_pkg::CFG_TYPE1) begin
			cfg_addr = {8'h00, r.tsel[23:2], pcab_pkg::CFG_TYPE1};
		end else begin
			cfg_addr = {idsel, r.tsel[10:8], r.tsel[7:2], pcab_pkg::CFG_TYPE0};
		end
	end

	// width and low port bits to lanes
	always_comb begin
		case (host_size)
			pcab_pkg::SIZE_8: io_be = 4'(4'h1 << host_addr[1:0]);
			pcab_pkg::SIZE_16: io_be = 4'(4'h3 << host_addr[1:0]);
			default: io_be = 4'hf;
		endcase
	end

	// Sequencer and register file
	always_comb begin
		n = r;
		n.ack = 1'b0;
		n.beat = 1'b0;
		acc_sum = {1'b0, r.acc} + {1'b0, pcab_pkg::ACC_STEP};
		tick = acc_sum >= pcab_pkg::ACC_MOD;
		n.acc = tick ? 6'(acc_sum - pcab_pkg::ACC_MOD) : acc_sum[5:0];
		n.bus_clk = tick;
		// Stale strobes and data from the last beat are ignored until this runs out
		n.lat = (r.lat != 3'h0) ? 3'(r.lat - 3'h1) : 3'h0;
		case (r.st)
			pcab_pkg::ST_IDLE: begin
				n.busy = 1'b0;
				if (host_req) begin
					n.busy = 1'b1;
					n.abort = 1'b0;
					n.wr = host_wr;
					n.left = 8'h01;
					n.wait_cnt = 4'h0;
					n.be = io_be;
					n.st = pcab_pkg::ST_ADDR;
					case (host_kind)
						pcab_pkg::KIND_IO: begin
							n.addr = {16'h0000, host_addr[15:0]};
							n.cmd = host_wr ? pcab_pkg::CMD_IO_WR : pcab_pkg::CMD_IO_RD;
							if (host_addr[15:0] == pcab_pkg::PORT_TSEL && host_size[1]) begin
								n.st = pcab_pkg::ST_DONE;
								n.rdata = r.tsel;
								if (host_wr) begin
									n.tsel = host_wdata & pcab_pkg::TSEL_WMASK;
								end
							end else if (host_addr[15:2] == pcab_pkg::PORT_DWIN[15:2]
									&& r.tsel[pcab_pkg::TSEL_EN_BIT]) begin
								n.addr = cfg_addr;
								n.cmd = host_wr ? pcab_pkg::CMD_CFG_WR : pcab_pkg::CMD_CFG_RD;
							end
						end
						pcab_pkg::KIND_MEM: begin
							n.addr = {host_addr[31:2], 2'b00};
							n.cmd = host_wr ? pcab_pkg::CMD_MEM_WR : pcab_pkg::CMD_MEM_RD;
							n.be = 4'hf;
							n.left = (host_len == 8'h00) ? 8'h01 : host_len;
						end
						default: begin
							n.addr = 32'h0000_0000;
							n.cmd = pcab_pkg::CMD_SPECIAL;
							n.wr = 1'b1;
							n.be = 4'hf;
						end
					endcase
				end
			end
			pcab_pkg::ST_ADDR: begin
				if (tick) begin
					n.ad_o = r.addr;
					n.ad_oe = 1'b1;
					n.cbe_o = r.cmd;
					n.cbe_oe = 1'b1;
					n.frame_n = 1'b0;
					n.frame_oe = 1'b1;
					n.irdy_n = 1'b1;
					n.irdy_oe = 1'b1;
					n.st = pcab_pkg::ST_DATA;
				end
			end
			pcab_pkg::ST_DATA: begin
				if (tick) begin
					if (r.irdy_n) begin
						n.irdy_n = 1'b0;
						n.ad_o = host_wdata;
						n.ad_oe = r.wr;
						n.cbe_o = ~r.be;
						n.frame_n = (r.left == 8'h01);
						n.wait_cnt = 4'h0;
						n.lat = pcab_pkg::SYNC_LAT;
					end else if (r.lat == 3'h0 && devsel_ok && trdy_ok) begin
						n.beat = 1'b1;
						n.rdata = r.wr ? r.ad_o : ad_seen;
						n.irdy_n = 1'b1;
						n.left = 8'(r.left - 8'h01);
						n.addr = 32'(r.addr + 32'h4);
						if (r.left == 8'h01) begin
							n.ad_oe = 1'b0;
							n.cbe_oe = 1'b0;
							n.frame_n = 1'b1;
							n.st = pcab_pkg::ST_TURN;
						end
						// no new address phase, burst continues
					end else if (!devsel_ok) begin
						n.wait_cnt = 4'(r.wait_cnt + 4'h1);
						if (r.wait_cnt == pcab_pkg::DEVSEL_WAIT - 4'h1) begin
							n.abort = 1'b1;
							n.rdata = 32'hffff_ffff;
							n.irdy_n = 1'b1;
							n.frame_n = 1'b1;
							n.ad_oe = 1'b0;
							n.cbe_oe = 1'b0;
							n.st = pcab_pkg::ST_TURN;
						end
					end
				end
			end
			pcab_pkg::ST_TURN: begin
				if (tick) begin
					n.frame_oe = 1'b0;
					n.irdy_oe = 1'b0;
					n.st = pcab_pkg::ST_DONE;
				end
			end
			pcab_pkg::ST_DONE: begin
				n.ack = 1'b1;
				n.busy = 1'b0;
				n.st = pcab_pkg::ST_IDLE;
			end
			default: begin
				n.st = pcab_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			r <= '{st: pcab_pkg::ST_IDLE, acc: pcab_pkg::ACC_RESET, tsel: pcab_pkg::TSEL_RESET,
				left: 8'h00, wait_cnt: 4'h0, frame_n: 1'b1, irdy_n: 1'b1, cbe_o: 4'hf,
				default: '0};
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign host_ack = r.ack;
	assign host_beat = r.beat;
	assign host_busy = r.busy;
	assign host_abort = r.abort;
	assign host_rdata = r.rdata;
	assign bus_clk = r.bus_clk;
	assign ad_out = r.ad_o;
	assign ad_oe = r.ad_oe;
	assign cbe_out = r.cbe_o;
	assign cbe_oe = r.cbe_oe;
	assign frame_n_out = r.frame_n;
	assign frame_oe = r.frame_oe;
	assign irdy_n_out = r.irdy_n;
	assign irdy_oe = r.irdy_oe;

endmodule : pcab_bridge

// *** rtl/pcab_pkg.sv ***
package pcab_pkg;

	// Software-visible I/O ports
	localparam logic [15:0] PORT_TSEL = 16'h0cf8;
	localparam logic [15:0] PORT_DWIN = 16'h0cfc;

	// Target-select register layout and reset value
	localparam logic [31:0] TSEL_RESET = 32'h0000_0000;
	localparam logic [31:0] TSEL_WMASK = 32'h80ff_ffff;
	localparam int TSEL_EN_BIT = 31;
	localparam int TSEL_BUS_LSB = 16;
	localparam int TSEL_DEV_LSB = 11;
	localparam int TSEL_FUNC_LSB = 8;
	localparam int TSEL_REG_LSB = 2;
	localparam logic [1:0] CFG_TYPE0 = 2'h0;
	localparam logic [1:0] CFG_TYPE1 = 2'h1;
	localparam logic [4:0] IDSEL_MAX_DEV = 5'h14;

	// Bus command codes carried in the address phase
	localparam logic [3:0] CMD_SPECIAL = 4'h1;
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'ha;
	localparam logic [3:0] CMD_CFG_WR = 4'hb;

	// Host request kinds and access sizes
	localparam logic [1:0] KIND_IO = 2'h0;
	localparam logic [1:0] KIND_MEM = 2'h1;
	localparam logic [1:0] KIND_SPECIAL = 2'h2;
	localparam logic [1:0] SIZE_8 = 2'h0;
	localparam logic [1:0] SIZE_16 = 2'h1;
	localparam logic [1:0] SIZE_32 = 2'h2;

	// Bus rate derived from the reference clock by a phase accumulator
	localparam int REF_MHZ = 40;
	localparam int BUS_MHZ = 33;
	localparam logic [5:0] ACC_STEP = 6'(BUS_MHZ);
	localparam logic [6:0] ACC_MOD = 7'(REF_MHZ);
	localparam logic [5:0] ACC_RESET = 6'h00;

	// Bus periods to wait for a target claim before master abort
	localparam logic [3:0] DEVSEL_WAIT = 4'h6;

	// Reference cycles before a target response has crossed the synchroniser
	localparam logic [2:0] SYNC_LAT = 3'h4;

	// Synchroniser idle value: bus lines float high
	localparam logic [33:0] PIN_RESET = 34'h3_ffff_ffff;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_DATA = 3'b010,
		ST_TURN = 3'b011,
		ST_DONE = 3'b100
	} pcab_state_t;

endpackage : pcab_pkg

// *** rtl/pcab_pin_if.sv ***
`timescale 1ns/100ps
interface pcab_pin_if #(parameter int W = 34);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface : pcab_pin_if

// *** rtl/pcab_pin_sync.sv ***
`timescale 1ns/100ps
module pcab_pin_sync #(
	parameter int W = 34,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic ref_clk,
	input wire logic resetn,
	pcab_pin_if.sync pins
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} pcab_sync_t;

	pcab_sync_t r;
	pcab_sync_t n;
	logic [W-1:0] agree;

	// Three-stage shift; a bit changes only once stages two and three agree
	always_comb begin
		agree = ~(r.s2 ^ r.s3);
		n = r;
		n.s1 = pins.raw;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.q = (r.q & ~agree) | (r.s3 & agree);
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			r <= {INIT, INIT, INIT, INIT};
		end else begin
			r <= n;
		end
	end

	assign pins.clean = r.q;

endmodule : pcab_pin_sync

// *** testbench/pcab_bridge_checker.sv ***
`timescale 1ns/100ps
module pcab_bridge_checker (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic host_req,
	input wire logic [1:0] host_kind,
	input wire logic [31:0] host_addr,
	input wire logic [1:0] host_size,
	input wire logic host_ack,
	input wire logic host_beat,
	input wire logic host_busy,
	input wire logic host_abort,
	input wire logic [31:0] host_rdata,
	input wire logic bus_clk,
	input wire logic ad_oe,
	input wire logic [3:0] cbe_out,
	input wire logic cbe_oe,
	input wire logic frame_n_out,
	input wire logic frame_oe,
	input wire logic irdy_n_out
);
	// All checks on the reference clock, idle in reset
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	chk_oe_pair: assert property (ad_oe |-> cbe_oe)
		else $error("ad driven without cbe");
	chk_frame_drive: assert property (!frame_n_out |-> frame_oe)
		else $error("frame low while undriven");
	chk_addr_phase: assert property ($fell(frame_n_out) |-> irdy_n_out && ad_oe)
		else $error("address phase malformed");
	chk_bus_rate: assert property (!bus_clk && $past(bus_clk) |=> bus_clk)
		else $error("bus period gap too long");
	chk_cmd_code: assert property ($fell(frame_n_out) |->
		cbe_out inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb})
		else $error("unknown bus command");
	chk_tsel_ack: assert property (host_req && !host_busy && !host_ack && host_kind == 2'h0 && host_size[1]
		&& host_addr[15:0] == 16'h0cf8 |-> ##1 host_busy ##1 (host_ack && !host_busy))
		else $error("select access timing wrong");
	chk_abort_data: assert property ($rose(host_abort) |-> host_rdata == 32'hffff_ffff)
		else $error("abort without all-ones data");
	chk_ack_release: assert property (host_ack |-> !ad_oe && !frame_oe)
		else $error("bus still driven at ack");
	chk_beat_irdy: assert property (host_beat |-> irdy_n_out && !$past(irdy_n_out))
		else $error("beat without ready release");
endmodule : pcab_bridge_checker

bind pcab_bridge pcab_bridge_checker u_chk (.ref_clk, .resetn, .host_req, .host_kind, .host_addr, .host_size,
	.host_ack, .host_beat, .host_busy, .host_abort, .host_rdata, .bus_clk, .ad_oe, .cbe_out, .cbe_oe,
	.frame_n_out, .frame_oe, .irdy_n_out);

// *** testbench/pcab_target_model.sv ***
`timescale 1ns/100ps
module pcab_target_model (
	input wire logic ref_clk,
	input wire logic slow,
	input wire logic [31:0] ad_out,
	input wire logic [3:0] cbe_out,
	input wire logic frame_n_out,
	input wire logic irdy_n_out,
	output logic [31:0] ad_in,
	output logic trdy_n_in,
	output logic devsel_n_in,
	output logic [3:0] seen_cmd,
	output logic [31:0] seen_addr,
	output logic [3:0] seen_be,
	output logic [31:0] wr_data,
	output logic [7:0] nb
);
	localparam logic [31:0] KEY = 32'h5a5a_0000;
	logic act = 1'b0;
	logic claim = 1'b0;
	logic irdy_q = 1'b1;
	logic [31:0] cur = 32'h0;
	logic [31:0] ad_q = 32'h0;
	logic [3:0] wait_c = 4'h0;
	logic drv;
	// Strobes pulled up when unclaimed; data toggles when released
	assign drv = act && claim && !irdy_n_out && !seen_cmd[0];
	assign devsel_n_in = !(act && claim);
	assign trdy_n_in = !(act && claim && !irdy_n_out && wait_c == 4'h0);
	assign ad_in = drv ? cur ^ KEY : ~ad_q;
	// Address capture, claim decision and beat tracking
	always @(posedge ref_clk) begin
		ad_q <= ad_in;
		irdy_q <= irdy_n_out;
		if (!act && !frame_n_out) begin
			act <= 1'b1;
			seen_cmd <= cbe_out;
			seen_addr <= ad_out;
			cur <= ad_out;
			nb <= 8'h0;
			wait_c <= slow ? 4'h7 : 4'h0;
			claim <= cbe_out[3:1] == 3'h1 ? ad_out != 32'h0000_0bad :
				cbe_out[3:1] == 3'h3 ? ad_out[1:0] == 2'h0 :
				cbe_out[3:1] == 3'h5 ? ad_out[1:0] == 2'h1 || (ad_out[20] && ad_out[10:8] < 3'h4) : 1'b0;
		end else if (act && frame_n_out && irdy_n_out) begin
			act <= 1'b0;
		end
		if (act && !irdy_n_out) begin
			seen_be <= cbe_out;
			wait_c <= wait_c - 4'(wait_c != 4'h0);
			if (seen_cmd[0]) begin
				wr_data <= ad_out;
			end
		end
		if (act && !irdy_q && irdy_n_out) begin
			cur <= cur + 32'h4;
			nb <= nb + 8'h1;
			wait_c <= slow ? 4'h7 : 4'h0;
		end
	end
endmodule : pcab_target_model

// *** testbench/tb_pcab_bridge.sv ***
`timescale 1ns/100ps
module tb_pcab_bridge;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic host_req = 1'b0;
	logic host_wr = 1'b0;
	logic slow = 1'b0;
	logic [1:0] host_kind = 2'h0;
	logic [1:0] host_size = 2'h0;
	logic [7:0] host_len = 8'h0;
	logic [31:0] host_addr = 32'h0;
	logic [31:0] host_wdata = 32'h0;
	logic host_ack, host_beat, host_busy, host_abort, bus_clk, ad_oe, cbe_oe, frame_n_out, frame_oe;
	logic irdy_n_out, irdy_oe, trdy_n_in, devsel_n_in;
	logic [31:0] host_rdata, ad_in, ad_out, seen_addr, wr_data;
	logic [3:0] cbe_out, seen_cmd, seen_be;
	logic [7:0] nb;
	int miscompares = 0;
	int n_checks = 0;
	localparam logic [31:0] KEY = 32'h5a5a_0000;
	// Reference clock
	always #12.5 ref_clk = ~ref_clk;
	pcab_bridge u_dut (.ref_clk, .resetn, .host_req, .host_kind, .host_wr, .host_addr, .host_size, .host_len,
		.host_wdata, .host_ack, .host_beat, .host_busy, .host_abort, .host_rdata, .bus_clk, .ad_in, .ad_out,
		.ad_oe, .cbe_out, .cbe_oe, .frame_n_out, .frame_oe, .irdy_n_out, .irdy_oe, .trdy_n_in, .devsel_n_in);
	pcab_target_model u_target (.ref_clk, .slow, .ad_out, .cbe_out, .frame_n_out, .irdy_n_out, .ad_in,
		.trdy_n_in, .devsel_n_in, .seen_cmd, .seen_addr, .seen_be, .wr_data, .nb);
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// One host request, burst data stepped after each beat
	task automatic op(input logic [1:0] k, input logic w, input logic [31:0] a, input logic [1:0] s,
		input logic [7:0] n, input logic [31:0] d);
		int i;
		@(negedge ref_clk);
		{host_kind, host_wr, host_addr, host_size, host_len, host_wdata} = {k, w, a, s, n, d};
		host_req = 1'b1;
		@(negedge ref_clk);
		host_req = 1'b0;
		for (i = 0; i < 3000 && host_ack !== 1'b1; i++) begin
			if (host_beat === 1'b1) host_wdata = host_wdata + 32'h1;
			@(negedge ref_clk);
		end
		chk("ack", {31'h0, host_ack}, 32'h1);
		chk("idle_drive", {27'h0, host_busy, ad_oe, cbe_oe, frame_oe, irdy_oe}, 32'h0);
	endtask : op
	// Watchdog
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		end_sim();
	end
	// Test sequence
	initial begin
		repeat (5) @(negedge ref_clk);
		resetn = 1'b1;
		op(2'h0, 1'b0, 32'hcf8, 2'h2, 8'h1, 32'h0);
		chk("tsel_rst", host_rdata, 32'h0);
		op(2'h0, 1'b1, 32'hcf8, 2'h2, 8'h1, 32'hffff_ffff);
		op(2'h0, 1'b0, 32'hcf8, 2'h2, 8'h1, 32'h0);
		chk("tsel_mask", host_rdata, pcab_pkg::TSEL_WMASK);
		$display("test select done");
		op(2'h0, 1'b1, 32'hcf8, 2'h2, 8'h1, 32'h8000_4a14);
		op(2'h0, 1'b0, 32'hcfc, 2'h2, 8'h1, 32'h0);
		chk("t0_cmd", seen_cmd, pcab_pkg::CMD_CFG_RD);
		chk("t0_addr", seen_addr, 32'h0010_0214);
		chk("t0_data", host_rdata, 32'h0010_0214 ^ KEY);
		op(2'h0, 1'b1, 32'hcf8, 2'h2, 8'h1, 32'h8008_200d);
		op(2'h0, 1'b1, 32'hcfc, 2'h2, 8'h1, 32'hcafe_0001);
		chk("t1_cmd", seen_cmd, pcab_pkg::CMD_CFG_WR);
		chk("t1_addr", seen_addr, 32'h0008_200d);
		chk("t1_data", wr_data, 32'hcafe_0001);
		$display("test config done");
		op(2'h0, 1'b1, 32'hcf8, 2'h2, 8'h1, 32'h0000_4a14);
		op(2'h0, 1'b0, 32'hcfe, 2'h1, 8'h1, 32'h0);
		chk("off_cmd", seen_cmd, pcab_pkg::CMD_IO_RD);
		chk("off_addr", seen_addr, 32'h0000_0cfe);
		chk("off_be", seen_be, 4'h3);
		op(2'h0, 1'b0, 32'hcf8, 2'h0, 8'h1, 32'h0);
		chk("narrow", seen_addr, 32'h0000_0cf8);
		op(2'h0, 1'b1, 32'h61, 2'h0, 8'h1, 32'h0000_a500);
		chk("io_cmd", seen_cmd, pcab_pkg::CMD_IO_WR);
		chk("io_be", seen_be, 4'hd);
		chk("io_data", wr_data & 32'h0000_ff00, 32'h0000_a500);
		op(2'h0, 1'b0, 32'hbad, 2'h2, 8'h1, 32'h0);
		chk("abort", {31'h0, host_abort}, 32'h1);
		chk("abort_data", host_rdata, 32'hffff_ffff);
		$display("test io done");
		op(2'h1, 1'b0, 32'h1000_0010, 2'h2, 8'h4, 32'h0);
		chk("abort_clr", {31'h0, host_abort}, 32'h0);
		chk("mr_cmd", seen_cmd, pcab_pkg::CMD_MEM_RD);
		chk("mr_addr", seen_addr, 32'h1000_0010);
		chk("mr_beats", nb, 32'h4);
		chk("mr_data", host_rdata, 32'h1000_001c ^ KEY);
		slow = 1'b1;
		op(2'h1, 1'b1, 32'h2000_0000, 2'h2, 8'h3, 32'h0000_0100);
		slow = 1'b0;
		chk("mw_cmd", seen_cmd, pcab_pkg::CMD_MEM_WR);
		chk("mw_beats", nb, 32'h3);
		chk("mw_data", wr_data, 32'h0000_0102);
		op(2'h2, 1'b1, 32'h0, 2'h2, 8'h1, 32'h0000_1234);
		chk("sp_cmd", seen_cmd, pcab_pkg::CMD_SPECIAL);
		$display("test memory done");
		// Reset in mid-run clears the target-select register
		@(negedge ref_clk);
		resetn = 1'b0;
		repeat (2) @(negedge ref_clk);
		resetn = 1'b1;
		op(2'h0, 1'b0, 32'hcf8, 2'h2, 8'h1, 32'h0);
		chk("tsel_rerst", host_rdata, pcab_pkg::TSEL_RESET);
		$display("test reset done");
		end_sim();
	end
endmodule : tb_pcab_bridge
